// >>> rtl/tadsc_pkg.sv
// Shared constants and types for the touch converter serial control block.
package tadsc_pkg;

	// Control byte layout, indexed from the start bit down.
	localparam int CTRL_BITS = 8;
	localparam int RESULT_BITS = 12;
	localparam int CHAN_MSB = 6;
	localparam int CHAN_LSB = 4;
	localparam int REF_MODE_POS = 2;
	localparam int PEN_OFF_POS = 0;
	localparam logic [7:0] CTRL_START_VALUE = 8'h80;
	localparam logic [3:0] RX_COUNT_FULL = 4'h8;
	localparam logic [3:0] RX_COUNT_ONE = 4'h1;

	// Falling edge numbers of a transaction, counted from the start bit.
	localparam logic [4:0] TRACK_START_FALL = 5'h05;
	localparam logic [4:0] TRACK_END_FALL = 5'h08;
	localparam logic [4:0] BUSY_FALL = 5'h08;
	localparam logic [4:0] FIRST_DECIDE_FALL = 5'h09;
	localparam logic [4:0] LAST_DECIDE_FALL = 5'h14;
	localparam logic [4:0] DONE_FALL = 5'h15;

	// Channel codes of the control byte.
	localparam logic [2:0] CH_Y_POSITION = 3'h1;
	localparam logic [2:0] CH_X_POSITION = 3'h5;
	localparam logic [2:0] CH_AUX_A = 3'h2;
	localparam logic [2:0] CH_AUX_B = 3'h6;

	// Converter input multiplexer selection.
	typedef enum logic [2:0] {
		MUX_NONE,
		MUX_X_PLATE_POS,
		MUX_Y_PLATE_POS,
		MUX_AUX_IN_A,
		MUX_AUX_IN_B
	} tadsc_mux_t;

	// Converter reference routing.
	typedef enum logic [1:0] {
		REF_EXT_GND,
		REF_Y_PLATES,
		REF_X_PLATES
	} tadsc_ref_t;

endpackage : tadsc_pkg

// >>> rtl/tadsc_sar.sv
// Successive-approximation register that decides one result bit per step.
`timescale 1ns/100ps
module tadsc_sar import tadsc_pkg::*; #(
	parameter int WIDTH = RESULT_BITS
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic reset,
	// Step control.
	input wire logic clear,
	input wire logic step,
	input wire logic compare_high,
	// Trial code to the converter and the result so far.
	output logic [WIDTH-1:0] trial_code,
	output logic [WIDTH-1:0] result
);

	logic [WIDTH-1:0] result_r, result_nxt;
	logic [WIDTH-1:0] bit_r, bit_nxt;

	// Each step keeps or drops the bit under trial and moves one bit down.
	always_comb begin
		result_nxt = result_r;
		bit_nxt = bit_r;
		if (clear) begin
			result_nxt = '0;
			bit_nxt = {1'b1, {(WIDTH-1){1'b0}}};
		end else if (step) begin
			if (compare_high) begin
				result_nxt = result_r | bit_r;
			end
			bit_nxt = bit_r >> 1;
		end
	end

	// Registers of the approximation.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			result_r <= '0;
			bit_r <= '0;
		end else begin
			result_r <= result_nxt;
			bit_r <= bit_nxt;
		end
	end

	// The trial code holds decided bits plus the bit now being tried.
	assign trial_code = result_r | bit_r;
	assign result = result_r;

endmodule : tadsc_sar

// >>> rtl/tadsc_serial_ctrl.sv
// Serial control, channel routing and conversion sequencing of the touch converter.
//
// Contract
// - Serial input bits are taken on rising edges of serial_clock.
// - While chip select is high, input is ignored and nothing is shifted.
// - serial_out changes only on falling edges of serial_clock, and is cleared when chip select goes high.
// - serial_out and busy are released while chip select is high.
// - busy is high for exactly one serial clock period before the MSB decision.
// - serial_clock alone paces shifting and conversion steps.
// - Tracking runs from the fifth to the eighth falling edge, then holds.
// - Conversion is successive approximation, twelve bits, one per step.
// - Single-ended mode uses the external reference and ground.
// - Differential mode uses the matching plate pair as references.
// - The input multiplexer picks plates or auxiliary inputs by channel_select.
// - Channels: x_plate_pos 1, y_plate_pos 2, aux_in_a 3, aux_in_b 4.
// - Codes 001, 101, 010, 110 select Y, X, aux A, aux B; rest reserved.
// - ref_mode_select high means single-ended, low means differential.
// - Leading zeros are skipped; the first one is the start bit.
// - Differential 001 references Y plates, 101 references X plates.
// - After busy, twelve falling edges present the decisions, MSB first.
`timescale 1ns/100ps
module tadsc_serial_ctrl import tadsc_pkg::*; (
	// Clock and reset.
	input wire logic clock,
	input wire logic reset,
	// Serial port pins.
	input wire logic serial_clock,
	input wire logic chip_select_n,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_oe,
	output logic busy,
	output logic busy_oe,
	// Pen interrupt, open drain.
	input wire logic touch_sense,
	output logic pen_touch_irq_n_o,
	output logic pen_touch_irq_n_oe,
	// Analog front end control.
	input wire logic compare_high,
	output tadsc_mux_t mux_select,
	output tadsc_ref_t ref_select,
	output logic x_drive_on,
	output logic y_drive_on,
	output logic track_on,
	output logic [RESULT_BITS-1:0] dac_code
);

	typedef enum logic [1:0] {ST_IDLE, ST_CONTROL, ST_CONVERT, ST_DONE} tadsc_state_t;

	// Maps a channel code to the converter input.
	function automatic tadsc_mux_t chan_mux(input logic [2:0] ch);
		case (ch)
			CH_Y_POSITION: chan_mux = MUX_X_PLATE_POS;
			CH_X_POSITION: chan_mux = MUX_Y_PLATE_POS;
			CH_AUX_A: chan_mux = MUX_AUX_IN_A;
			CH_AUX_B: chan_mux = MUX_AUX_IN_B;
			default: chan_mux = MUX_NONE;
		endcase
	endfunction : chan_mux

	// Maps channel code and reference mode to the reference routing.
	function automatic tadsc_ref_t chan_ref(input logic [2:0] ch, input logic single);
		if (single) begin
			chan_ref = REF_EXT_GND;
		end else if (ch == CH_Y_POSITION) begin
			chan_ref = REF_Y_PLATES;
		end else if (ch == CH_X_POSITION) begin
			chan_ref = REF_X_PLATES;
		end else begin
			chan_ref = REF_EXT_GND;
		end
	endfunction : chan_ref

	// Two-stage synchronisers for the pins, plus a delayed copy for edges.
	logic sclk_s1_r, sclk_s2_r, sclk_d_r;
	logic cs_s1_r, cs_s2_r;
	logic din_s1_r, din_s2_r;
	logic touch_s1_r, touch_s2_r;
	logic rise_edge, fall_edge, cs_high;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sclk_s1_r <= 1'b0;
			sclk_s2_r <= 1'b0;
			sclk_d_r <= 1'b0;
			cs_s1_r <= 1'b1;
			cs_s2_r <= 1'b1;
			din_s1_r <= 1'b0;
			din_s2_r <= 1'b0;
			touch_s1_r <= 1'b0;
			touch_s2_r <= 1'b0;
		end else begin
			sclk_s1_r <= serial_clock;
			sclk_s2_r <= sclk_s1_r;
			sclk_d_r <= sclk_s2_r;
			cs_s1_r <= chip_select_n;
			cs_s2_r <= cs_s1_r;
			din_s1_r <= serial_in;
			din_s2_r <= din_s1_r;
			touch_s1_r <= touch_sense;
			touch_s2_r <= touch_s1_r;
		end
	end

	// Serial clock edges count only while chip select is low.
	assign cs_high = cs_s2_r;
	assign rise_edge = sclk_s2_r & ~sclk_d_r & ~cs_high;
	assign fall_edge = ~sclk_s2_r & sclk_d_r & ~cs_high;

	tadsc_state_t state_r, state_nxt;
	logic [CTRL_BITS-1:0] ctrl_r, ctrl_nxt;
	logic [3:0] rx_cnt_r, rx_cnt_nxt;
	logic [4:0] fall_cnt_r, fall_cnt_nxt;
	logic track_r, track_nxt;
	logic busy_r, busy_nxt;
	logic dout_r, dout_nxt;
	logic pen_en_r, pen_en_nxt;
	logic sar_clear, sar_step;
	logic [2:0] chan;
	logic single_mode, plates_on;

	assign chan = ctrl_r[CHAN_MSB:CHAN_LSB];
	assign single_mode = ctrl_r[REF_MODE_POS];

	// Sequencer: control byte reception, tracking window, busy and decisions.
	always_comb begin
		state_nxt = state_r;
		ctrl_nxt = ctrl_r;
		rx_cnt_nxt = rx_cnt_r;
		fall_cnt_nxt = fall_cnt_r;
		track_nxt = track_r;
		busy_nxt = busy_r;
		dout_nxt = dout_r;
		pen_en_nxt = pen_en_r;
		sar_clear = 1'b0;
		sar_step = 1'b0;
		if (cs_high) begin
			state_nxt = ST_IDLE;
			track_nxt = 1'b0;
			busy_nxt = 1'b0;
			dout_nxt = 1'b0;
		end else begin
			case (state_r)
				ST_IDLE, ST_DONE: begin
					if (rise_edge && din_s2_r) begin
						state_nxt = ST_CONTROL;
						ctrl_nxt = CTRL_START_VALUE;
						rx_cnt_nxt = RX_COUNT_ONE;
						fall_cnt_nxt = '0;
						sar_clear = 1'b1;
					end
				end
				ST_CONTROL, ST_CONVERT: begin
					if (rise_edge && state_r == ST_CONTROL) begin
						ctrl_nxt[CTRL_BITS - 1 - 32'(rx_cnt_r)] = din_s2_r;
						rx_cnt_nxt = rx_cnt_r + 4'h1;
						if (rx_cnt_nxt == RX_COUNT_FULL) begin
							state_nxt = ST_CONVERT;
							pen_en_nxt = ~din_s2_r; // Low pen-off bit enables the interrupt.
						end
					end
					if (fall_edge) begin
						fall_cnt_nxt = fall_cnt_r + 5'h01;
						if (fall_cnt_nxt == TRACK_START_FALL) begin
							track_nxt = 1'b1;
						end
						if (fall_cnt_nxt == TRACK_END_FALL) begin
							track_nxt = 1'b0;
						end
						busy_nxt = (fall_cnt_nxt == BUSY_FALL);
						if (fall_cnt_nxt >= FIRST_DECIDE_FALL && fall_cnt_nxt <= LAST_DECIDE_FALL) begin
							sar_step = 1'b1;
							dout_nxt = compare_high;
						end
						if (fall_cnt_nxt == DONE_FALL) begin
							dout_nxt = 1'b0;
							state_nxt = ST_DONE;
						end
					end
				end
				default: state_nxt = ST_IDLE;
			endcase
		end
	end

	// Sequencer registers.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state_r <= ST_IDLE;
			ctrl_r <= '0;
			rx_cnt_r <= '0;
			fall_cnt_r <= '0;
			track_r <= 1'b0;
			busy_r <= 1'b0;
			dout_r <= 1'b0;
			pen_en_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			ctrl_r <= ctrl_nxt;
			rx_cnt_r <= rx_cnt_nxt;
			fall_cnt_r <= fall_cnt_nxt;
			track_r <= track_nxt;
			busy_r <= busy_nxt;
			dout_r <= dout_nxt;
			pen_en_r <= pen_en_nxt;
		end
	end

	// Plates stay biased while tracking; differential keeps them through conversion.
	assign plates_on = (state_r == ST_CONTROL || state_r == ST_CONVERT)
		&& fall_cnt_r >= TRACK_START_FALL
		&& (single_mode ? fall_cnt_r < TRACK_END_FALL : fall_cnt_r <= LAST_DECIDE_FALL);

	tadsc_sar #(.WIDTH(RESULT_BITS)) u_sar (
		.clock(clock),
		.reset(reset),
		.clear(sar_clear),
		.step(sar_step),
		.compare_high(compare_high),
		.trial_code(dac_code),
		.result()
	);

	// Pin drive and analog routing outputs.
	assign serial_out = dout_r;
	assign serial_out_oe = ~cs_high;
	assign busy = busy_r;
	assign busy_oe = ~cs_high;
	assign track_on = track_r;
	assign mux_select = (state_r == ST_IDLE) ? MUX_NONE : chan_mux(chan);
	assign ref_select = chan_ref(chan, single_mode);
	assign y_drive_on = plates_on && chan == CH_Y_POSITION;
	assign x_drive_on = plates_on && chan == CH_X_POSITION;
	assign pen_touch_irq_n_o = 1'b0;
	assign pen_touch_irq_n_oe = touch_s2_r && pen_en_r
		&& (state_r == ST_IDLE || state_r == ST_DONE);

	// Checks of the sequencing against the serial clock.
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_shift_on_rise: assert property ($changed(rx_cnt_r) && state_r != ST_IDLE |-> $past(rise_edge))
		else $error("control bit count moved without a rising edge");
	a_ignore_cs_high: assert property (cs_high |=> state_r == ST_IDLE && !busy_r)
		else $error("sequencer active while chip select high");
	a_dout_on_fall: assert property ($changed(dout_r) |-> $past(fall_edge) || $past(cs_high))
		else $error("serial_out changed away from a falling edge");
	a_tristate_cs: assert property (cs_high |-> !serial_out_oe && !busy_oe)
		else $error("outputs driven while chip select high");
	a_busy_one_period: assert property ($rose(busy_r) |-> $past(fall_edge) && fall_cnt_r == BUSY_FALL)
		else $error("busy rose at the wrong falling edge");
	a_busy_ends_msb: assert property ($fell(busy_r) && !cs_high |-> fall_cnt_r == FIRST_DECIDE_FALL)
		else $error("busy did not end at the MSB decision");
	a_track_window: assert property (track_r |-> fall_cnt_r >= TRACK_START_FALL && fall_cnt_r < TRACK_END_FALL)
		else $error("tracking outside the acquisition window");
	a_decide_count: assert property (fall_edge && fall_cnt_r == LAST_DECIDE_FALL && state_r == ST_CONVERT |=> state_r == ST_DONE)
		else $error("conversion did not finish after twelve decisions");
	a_single_ref: assert property (state_r == ST_CONVERT && single_mode |-> ref_select == REF_EXT_GND)
		else $error("single-ended mode not on external reference");
	a_reserved_off: assert property (chan_mux(chan) == MUX_NONE |-> !x_drive_on && !y_drive_on)
		else $error("plate driver on for a reserved code");
	a_start_bit: assert property (state_r == ST_IDLE && rise_edge && !din_s2_r && !cs_high |=> state_r == ST_IDLE)
		else $error("leading zero taken as start bit");

	c_full_convert: cover property (state_r == ST_CONVERT ##1 state_r == ST_DONE);
	c_differential: cover property (state_r == ST_CONVERT && !single_mode && x_drive_on);
	c_reserved: cover property (state_r == ST_CONVERT && chan_mux(chan) == MUX_NONE);
	c_abort: cover property (state_r == ST_CONVERT ##1 cs_high);

endmodule : tadsc_serial_ctrl

// >>> verification/tadsc_host.sv
// Host serial master model that sends a control byte and reads back the result.
`timescale 1ns/100ps
module tadsc_host (
	// System clock that paces the model.
	input wire logic clock,
	// Serial pins.
	output logic serial_clock,
	output logic chip_select_n,
	output logic serial_in,
	input wire logic dout_pin,
	input wire logic busy_pin,
	// Received frame.
	output logic [11:0] rx_word,
	output logic [3:0] rx_busy,
	output logic rx_valid
);
	// Serial clock idles low; two stray pulses precede each frame while chip select is high.
	initial begin
		serial_clock = 1'b0;
		chip_select_n = 1'b1;
		serial_in = 1'b0;
		rx_word = 12'h000;
		rx_busy = 4'h0;
		rx_valid = 1'b0;
	end

	// Waits a number of system clocks.
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick

	// Sends stray clocks, leading zeros and the control byte, then reads the result.
	task automatic frame(input logic [7:0] ctrl, input int zeros, input int rises);
		logic [11:0] w;
		logic [3:0] b;
		int k;
		w = 12'h000;
		b = 4'h0;
		serial_in <= 1'b1;
		for (k = 0; k < 2; k++) begin
			tick(4);
			serial_clock <= 1'b1;
			tick(4);
			serial_clock <= 1'b0;
		end
		chip_select_n <= 1'b0;
		tick(5);
		for (k = -zeros; k < rises; k++) begin
			serial_in <= (k >= 0 && k < 8) ? ctrl[7 - k] : 1'b0;
			tick(4);
			serial_clock <= 1'b1;
			if (busy_pin) b = b + 4'h1;
			if (k >= 9 && k <= 20) w = {w[10:0], dout_pin};
			tick(4);
			serial_clock <= 1'b0;
		end
		tick(4);
		chip_select_n <= 1'b1;
		serial_in <= ~ctrl[0];
		rx_word <= w;
		rx_busy <= b;
		rx_valid <= (rises > 20);
		tick(1);
		rx_valid <= 1'b0;
	endtask : frame
endmodule : tadsc_host

// >>> verification/tadsc_serial_ctrl_tb_top.sv
// Self-checking testbench of the touch converter serial control block.
`timescale 1ns/100ps
module tadsc_serial_ctrl_tb_top import tadsc_pkg::*;;
	logic clock, reset, touch_sense, compare_high;
	logic toggle = 1'b0;
	logic track_d = 1'b0;
	logic [6:0] route_d = 7'h00;
	logic [11:0] analog;
	wire serial_clock, chip_select_n, serial_in, serial_out, serial_out_oe;
	wire busy, busy_oe, pen_o, pen_oe, x_drive_on, y_drive_on, track_on, rx_valid;
	wire dout_pin, busy_pin;
	wire [11:0] dac_code, rx_word;
	wire [3:0] rx_busy;
	tadsc_mux_t mux_select;
	tadsc_ref_t ref_select;
	int num_errors = 0;
	int tests_run = 0;
	int cyc = 0;
	logic [31:0] lfsr = 32'hEA35A637;
	logic [15:0] res_q[$];
	logic [6:0] route_q[$];

	// Released pins show a changing pattern instead of a held value.
	assign dout_pin = serial_out_oe ? serial_out : toggle;
	assign busy_pin = busy_oe ? busy : ~toggle;
	assign compare_high = (analog >= dac_code);

	tadsc_serial_ctrl i_tadsc_serial_ctrl (.clock(clock), .reset(reset),
		.serial_clock(serial_clock), .chip_select_n(chip_select_n), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe), .busy(busy),
		.busy_oe(busy_oe), .touch_sense(touch_sense), .pen_touch_irq_n_o(pen_o),
		.pen_touch_irq_n_oe(pen_oe), .compare_high(compare_high),
		.mux_select(mux_select), .ref_select(ref_select), .x_drive_on(x_drive_on),
		.y_drive_on(y_drive_on), .track_on(track_on), .dac_code(dac_code));
	tadsc_host i_tadsc_host (.clock(clock), .serial_clock(serial_clock),
		.chip_select_n(chip_select_n), .serial_in(serial_in), .dout_pin(dout_pin),
		.busy_pin(busy_pin), .rx_word(rx_word), .rx_busy(rx_busy), .rx_valid(rx_valid));

	// Free-running system clock.
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : next_rand

	// Expected mux, reference and drivers for a channel code and mode.
	function automatic logic [6:0] exp_route(input logic [2:0] c, input logic se);
		tadsc_mux_t m;
		tadsc_ref_t r;
		m = (c == CH_Y_POSITION) ? MUX_X_PLATE_POS : (c == CH_X_POSITION) ? MUX_Y_PLATE_POS :
			(c == CH_AUX_A) ? MUX_AUX_IN_A : (c == CH_AUX_B) ? MUX_AUX_IN_B : MUX_NONE;
		r = se ? REF_EXT_GND : (c == CH_Y_POSITION) ? REF_Y_PLATES :
			(c == CH_X_POSITION) ? REF_X_PLATES : REF_EXT_GND;
		return {m, r, c == CH_X_POSITION, c == CH_Y_POSITION};
	endfunction : exp_route

	task automatic check_res(input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED result at %0t: expected %h got %h", $time, e, g);
		end
	endtask : check_res

	task automatic check_route(input logic [6:0] e, input logic [6:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED route at %0t: expected %h got %h", $time, e, g);
		end
	endtask : check_route

	task automatic check_pin(input logic [3:0] e, input logic [3:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED enables at %0t: expected %h got %h", $time, e, g);
		end
	endtask : check_pin

	task automatic test_done();
		$display("Checks run %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : test_done

	// Monitor: results and routing are matched against the oldest notes.
	always @(posedge clock) begin
		toggle <= ~toggle;
		track_d <= track_on;
		route_d <= {mux_select, ref_select, x_drive_on, y_drive_on};
		cyc <= cyc + 1;
		if (rx_valid && res_q.size() > 0)
			check_res(res_q.pop_front(), {rx_busy, rx_word});
		// Routing is taken from the last tracking cycle, when the whole control byte is in.
		if (!track_on && track_d && route_q.size() > 0)
			check_route(route_q.pop_front(), route_d);
		if (cyc == 40000) begin
			num_errors++;
			test_done();
		end
	end

	// Main sequence: every channel code in both modes, an abort, then recovery.
	initial begin
		logic [7:0] ctrl;
		logic [11:0] v;
		reset = 1'b1;
		touch_sense = 1'b0;
		analog = 12'h000;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		repeat (3) @(posedge clock);
		for (int i = 0; i < 18; i++) begin
			lfsr = next_rand(lfsr);
			v = (i == 0) ? 12'hFFF : (i == 1) ? 12'h000 : lfsr[11:0];
			ctrl = {1'b1, i[2:0], 1'b0, i[3], 1'b0, lfsr[12]};
			analog <= v;
			touch_sense <= lfsr[13];
			route_q.push_back(exp_route(i[2:0], i[3]));
			if (i == 16) begin
				i_tadsc_host.frame(ctrl, 1, 12);
			end else begin
				res_q.push_back({4'h1, v});
				i_tadsc_host.frame(ctrl, int'(lfsr[16:14]), 24);
			end
			repeat (4) @(posedge clock);
			// Pins released; pen pull-down follows touch when the pen-off bit is clear.
			check_pin({3'b000, lfsr[13] & ~lfsr[12]}, {serial_out_oe, busy_oe, pen_o, pen_oe});
		end
		// Every noted result and route must have been matched.
		check_res(16'h0000, 16'(res_q.size() + route_q.size()));
		test_done();
	end
endmodule : tadsc_serial_ctrl_tb_top
